// ---- src/cop_clock_control.sv ----
`include "cop_map.svh"
`default_nettype none

// Contract
// RULE1 - Address strap picks bus address at start
// RULE2 - Power-good low: pairs low, reference per history
// RULE3 - Pair runs only with bit set, pin low
// RULE4 - Spread strap latched at first power-up
// RULE5 - First power-good starts; later lows power down
// RULE6 - Pairs blocked until synthesizer reports lock
// RULE7 - Wake-on-LAN bit keeps reference in power-down
// RULE8 - Strap pin becomes buffered crystal reference
// RULE9 - Board drives enable pins, unconnected means on
// RULE10 - Pair start and stop within 1-3 periods
// RULE11 - Gate pairs only while clock is low
module cop_clock_control
    import cop_pkg::*;
#(
    parameter int NUM_PAIRS = 6
)(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    // Board pins and straps
    input wire logic power_good_n_powerdown,
    input wire logic [NUM_PAIRS-1:0] pair_enable_n,
    input wire logic [1:0] spread_strap,
    input wire logic xtal_level,
    input wire logic pll_lock,
    // Shared strap / reference pin
    input wire logic address_strap_in,
    output logic address_strap_out,
    output logic address_strap_oe_n,
    // Differential pairs
    output logic [NUM_PAIRS-1:0] diff_true,
    output logic [NUM_PAIRS-1:0] diff_comp,
    // Latched configuration
    output logic [6:0] smbus_addr,
    output cop_spread_e spread_sel,
    output logic synth_run
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cop_state_e state, next_state;
    cop_strap_s strap, next_strap;
    logic [6:0] next_smbus_addr;
    logic next_synth_run;
    logic synth_phase, next_phase;
    logic next_ref_out, next_ref_oe_n;
    logic [NUM_PAIRS-1:0] pair_en_bits, next_pair_en_bits;
    logic [7:0] cfg_byte3, next_cfg_byte3;
    logic [31:0] next_rdata;
    logic [31:0] status_word;
    logic [NUM_PAIRS-1:0] pair_running;
    logic wake_on_lan_mode;
    logic pg;
    logic ref_active;

    assign pg = power_good_n_powerdown;
    assign wake_on_lan_mode = cfg_byte3[`COP_CFG3_WOL_BIT];

    // Tri-level strap decode; the unused fourth code reads as high
    function automatic cop_spread_e spread_decode(input logic [1:0] lvl);
        if (lvl == `COP_TRI_LOW)
            return SPREAD_OFF;
        else if (lvl == `COP_TRI_MID)
            return SPREAD_QUARTER;
        else
            return SPREAD_HALF;
    endfunction

    // Bus address chosen by the strap level
    function automatic logic [6:0] busaddr_of(input logic strap_lvl);
        return strap_lvl ? `COP_BUSADDR_STRAP_HIGH : `COP_BUSADDR_STRAP_LOW;
    endfunction

    // ------------------------------------------------------------
    // Power sequencer
    // ------------------------------------------------------------
    // Straps are caught only on the very first power-good; later cycles reuse them
    always_comb
    begin
        next_state = state;
        next_strap = strap;
        unique case (state)
            ST_UNSTRAPPED:
            begin
                if (pg)
                begin
                    next_strap.addr = address_strap_in; // [RULE1]
                    next_strap.spread = spread_decode(spread_strap); // [RULE4]
                    next_state = ST_LOCKING; // [RULE5]
                end
            end
            ST_LOCKING:
            begin
                if (!pg)
                    next_state = ST_PDOWN; // [RULE5]
                else if (pll_lock)
                    next_state = ST_RUN; // [RULE6]
            end
            ST_RUN:
            begin
                if (!pg)
                    next_state = ST_PDOWN; // [RULE5]
                else if (!pll_lock)
                    next_state = ST_LOCKING; // [RULE6]
            end
            ST_PDOWN:
            begin
                if (pg)
                    next_state = ST_LOCKING; // [RULE5]
            end
        endcase
        next_smbus_addr = busaddr_of(next_strap.addr); // [RULE1]
        next_synth_run = (next_state == ST_LOCKING) || (next_state == ST_RUN);
        // Output phase runs at half the system clock while the synthesizer is on
        next_phase = next_synth_run ? ~synth_phase : 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= ST_UNSTRAPPED;
            strap <= '0;
            smbus_addr <= `COP_BUSADDR_STRAP_LOW;
            spread_sel <= SPREAD_OFF;
            synth_run <= 1'b0;
            synth_phase <= 1'b0;
        end
        else
        begin
            state <= next_state;
            strap <= next_strap;
            smbus_addr <= next_smbus_addr;
            spread_sel <= next_strap.spread;
            synth_run <= next_synth_run;
            synth_phase <= next_phase;
        end
    end

    // ------------------------------------------------------------
    // Reference output on the shared strap pin
    // ------------------------------------------------------------
    // Pin floats until first power-good so the strap can be read cleanly
    always_comb
    begin
        ref_active = (next_state == ST_LOCKING) || (next_state == ST_RUN)
            || ((next_state == ST_PDOWN) && wake_on_lan_mode); // [RULE7]
        next_ref_oe_n = (next_state == ST_UNSTRAPPED); // [RULE2] [RULE8]
        next_ref_out = ref_active & xtal_level; // [RULE8]
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            address_strap_out <= 1'b0;
            address_strap_oe_n <= 1'b1;
        end
        else
        begin
            address_strap_out <= next_ref_out;
            address_strap_oe_n <= next_ref_oe_n;
        end
    end

    // ------------------------------------------------------------
    // Differential pair gating
    // ------------------------------------------------------------
    // Power-down forces pairs low at once; lock loss stops them at the next low point
    cop_pair_gate #(
        .NUM_PAIRS(NUM_PAIRS)
    ) u_gate (
        .sys_clk(sys_clk),
        .rst(rst),
        .phase_next(next_phase),
        .allow(state == ST_RUN), // [RULE6]
        .force_off(!pg), // [RULE2] [RULE7]
        .en_bits(pair_en_bits),
        .pair_enable_n(pair_enable_n), // [RULE9]
        .true_leg(diff_true),
        .comp_leg(diff_comp),
        .running(pair_running)
    );

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Status packs sequencer state, latched straps and live pair activity
    always_comb
    begin
        status_word = '0;
        status_word[`COP_ST_STATE_LSB +: 2] = state;
        status_word[`COP_ST_LOCK_BIT] = pll_lock;
        status_word[`COP_ST_STRAP_BIT] = strap.addr;
        status_word[`COP_ST_SPREAD_LSB +: 2] = strap.spread;
        status_word[`COP_ST_BUSADDR_LSB +: 7] = smbus_addr;
        status_word[`COP_ST_RUN_LSB +: NUM_PAIRS] = pair_running;
    end

    // Writes take effect next edge; unmapped reads return zero, writes are dropped
    always_comb
    begin
        next_pair_en_bits = pair_en_bits;
        next_cfg_byte3 = cfg_byte3;
        next_rdata = '0;
        if (bus_wr)
        begin
            if (bus_addr == `COP_OFS_PAIR_EN)
                next_pair_en_bits = bus_wdata[NUM_PAIRS-1:0]; // [RULE3]
            else if (bus_addr == `COP_OFS_CFG3)
                next_cfg_byte3 = bus_wdata[7:0]; // [RULE7]
        end
        if (bus_rd)
        begin
            if (bus_addr == `COP_OFS_PAIR_EN)
                next_rdata[NUM_PAIRS-1:0] = pair_en_bits;
            else if (bus_addr == `COP_OFS_CFG3)
                next_rdata[7:0] = cfg_byte3;
            else if (bus_addr == `COP_OFS_STATUS)
                next_rdata = status_word;
        end
    end

    // Read data stands for one cycle only, then returns to zero
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pair_en_bits <= `COP_PAIR_EN_RST;
            cfg_byte3 <= `COP_CFG3_RST;
            bus_rdata <= '0;
        end
        else
        begin
            pair_en_bits <= next_pair_en_bits;
            cfg_byte3 <= next_cfg_byte3;
            bus_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_BUSADDR: assert property ( // [RULE1]
        @(posedge sys_clk) disable iff (rst)
        (state == ST_UNSTRAPPED && pg) |=> smbus_addr == busaddr_of($past(address_strap_in)))
        else $error("bus address does not follow the strap");

    AST_PG_LOW_PAIRS: assert property ( // [RULE2]
        @(posedge sys_clk) disable iff (rst)
        !pg |=> (diff_true == '0) && (diff_comp == '0))
        else $error("pair driven while power-good low");

    AST_REF_HIZ: assert property ( // [RULE2]
        @(posedge sys_clk) disable iff (rst)
        (state == ST_UNSTRAPPED) |-> address_strap_oe_n)
        else $error("reference driven before first power-good");

    AST_SPREAD: assert property ( // [RULE4]
        @(posedge sys_clk) disable iff (rst)
        (state == ST_UNSTRAPPED && pg) |=> spread_sel == spread_decode($past(spread_strap))
            ##1 $stable(spread_sel))
        else $error("spread selection not latched from strap");

    AST_PDOWN_ENTRY: assert property ( // [RULE5]
        @(posedge sys_clk) disable iff (rst)
        (state != ST_UNSTRAPPED && !pg) |=> state == ST_PDOWN ##1 (pg || state == ST_PDOWN))
        else $error("power-down not entered on low power-good");

    AST_LOCK_BLOCK: assert property ( // [RULE6]
        @(posedge sys_clk) disable iff (rst)
        (state != ST_RUN) [*4] |-> (diff_true == '0) && (diff_comp == '0))
        else $error("pairs running without synthesizer lock");

    AST_PDOWN_REF_LOW: assert property ( // [RULE7]
        @(posedge sys_clk) disable iff (rst)
        (state == ST_PDOWN && !wake_on_lan_mode && !pg) |=> !address_strap_out && !address_strap_oe_n)
        else $error("reference not held low in power-down");

    AST_REF_COPY: assert property ( // [RULE8]
        @(posedge sys_clk) disable iff (rst)
        (state == ST_RUN && pg) |=> !address_strap_oe_n && (address_strap_out == $past(xtal_level)))
        else $error("reference is not a copy of the crystal clock");

    AST_WOL_REF: assert property ( // [RULE7]
        @(posedge sys_clk) disable iff (rst)
        (state == ST_PDOWN && wake_on_lan_mode && !pg)
            |=> !address_strap_oe_n && (address_strap_out == $past(xtal_level)))
        else $error("reference stopped in wake-on-LAN power-down");

    AST_PDOWN_SYNTH_OFF: assert property ( // [RULE5]
        @(posedge sys_clk) disable iff (rst)
        (state == ST_PDOWN) |-> !synth_run)
        else $error("synthesizer still running in power-down");

endmodule

`default_nettype wire

// ---- src/cop_map.svh ----
`ifndef COP_MAP_SVH
`define COP_MAP_SVH

// ----------------------------------------------------------------
// Bus addresses answered on the management bus
// ----------------------------------------------------------------
`define COP_BUSADDR_STRAP_LOW 7'h68
`define COP_BUSADDR_STRAP_HIGH 7'h6a

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain port)
// ----------------------------------------------------------------
`define COP_OFS_PAIR_EN 8'h04
`define COP_OFS_STATUS 8'h08
`define COP_CFG3_INDEX 8'h03
`define COP_OFS_CFG3 (8'(`COP_CFG3_INDEX << 2))

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define COP_PAIR_EN_RST 6'h3f
`define COP_CFG3_RST 8'h5f
`define COP_CFG3_WOL_BIT 5
`define COP_ST_STATE_LSB 0
`define COP_ST_LOCK_BIT 2
`define COP_ST_STRAP_BIT 3
`define COP_ST_SPREAD_LSB 4
`define COP_ST_BUSADDR_LSB 8
`define COP_ST_RUN_LSB 16

// ----------------------------------------------------------------
// Tri-level strap codes and timing
// ----------------------------------------------------------------
`define COP_TRI_LOW 2'h0
`define COP_TRI_MID 2'h1
`define COP_TRI_HIGH 2'h2
`define COP_CLK_PERIOD_NS 50
`define COP_OUT_PERIOD_CYC 2

`endif

// ---- src/cop_pkg.sv ----
`default_nettype none

package cop_pkg;

    // Control sequencer states
    typedef enum logic [1:0] {
        ST_UNSTRAPPED,
        ST_LOCKING,
        ST_RUN,
        ST_PDOWN
    } cop_state_e;

    // Spread amount applied to the differential outputs
    typedef enum logic [1:0] {
        SPREAD_OFF,
        SPREAD_QUARTER,
        SPREAD_HALF
    } cop_spread_e;

    // Straps caught on the first power-good
    typedef struct packed {
        logic addr;
        cop_spread_e spread;
    } cop_strap_s;

    // Both legs of all pairs
    typedef struct packed {
        logic [5:0] true_leg;
        logic [5:0] comp_leg;
    } cop_diff_s;

endpackage

`default_nettype wire

// ---- src/cop_pair_gate.sv ----
`default_nettype none

module cop_pair_gate
    import cop_pkg::*;
#(
    parameter int NUM_PAIRS = 6
)(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control from the sequencer
    input wire logic phase_next,
    input wire logic allow,
    input wire logic force_off,
    input wire logic [NUM_PAIRS-1:0] en_bits,
    // Board enable pins, active low
    input wire logic [NUM_PAIRS-1:0] pair_enable_n,
    // Pair outputs
    output logic [NUM_PAIRS-1:0] true_leg,
    output logic [NUM_PAIRS-1:0] comp_leg,
    output logic [NUM_PAIRS-1:0] running
);

    logic [NUM_PAIRS-1:0] pin_q;
    logic [NUM_PAIRS-1:0] next_running;
    logic [NUM_PAIRS-1:0] next_true;
    logic [NUM_PAIRS-1:0] next_comp;

    // ------------------------------------------------------------
    // Per-pair gating
    // ------------------------------------------------------------
    // Apart from force_off, run state only moves where the true leg goes low, so enable changes never emit a runt
    always_comb
    begin
        for (int i = 0; i < NUM_PAIRS; i++)
        begin
            if (force_off)
                next_running[i] = 1'b0; // [RULE2]
            else if (!phase_next)
                next_running[i] = allow & en_bits[i] & ~pin_q[i]; // [RULE3] [RULE11]
            else
                next_running[i] = running[i];
            next_true[i] = next_running[i] & phase_next;
            next_comp[i] = next_running[i] & ~phase_next;
        end
    end

    // Pin sample plus one low point keeps the latency inside 1..3 output periods
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_q <= '1;
            running <= '0;
            true_leg <= '0;
            comp_leg <= '0;
        end
        else
        begin
            pin_q <= pair_enable_n; // [RULE10]
            running <= next_running;
            true_leg <= next_true;
            comp_leg <= next_comp;
        end
    end

    // ------------------------------------------------------------
    // Checks per pair
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_PAIRS; g++)
        begin : g_chk
            AST_PAIR_STOP: assert property ( // [RULE10]
                @(posedge sys_clk) disable iff (rst)
                pair_enable_n[g] [*5] |-> !true_leg[g] && !comp_leg[g])
                else $error("pair still driven after its enable pin deasserted");
            AST_PAIR_START: assert property ( // [RULE3]
                @(posedge sys_clk) disable iff (rst)
                (allow && en_bits[g] && !pair_enable_n[g] && !force_off) [*5] |-> (true_leg[g] ^ comp_leg[g]))
                else $error("enabled pair not running");
            AST_NO_RUNT: assert property ( // [RULE11]
                @(posedge sys_clk) disable iff (rst)
                $rose(true_leg[g]) |-> $past(comp_leg[g]) && !$past(true_leg[g]))
                else $error("true leg rose without a preceding low half");
        end
    endgenerate

endmodule

`default_nettype wire

// ---- verification/cop_board_model.sv ----
`default_nettype none

// ----
// Board side: strap resistor on the shared pin and synthesizer lock
// ----
module cop_board_model
#(
    parameter int LOCK_DELAY = 16
)(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // From the block
    input wire logic synth_run,
    input wire logic strap_out,
    input wire logic strap_oe_n,
    // Board strap resistor level
    input wire logic strap_level,
    // To the block
    output logic strap_in,
    output logic pll_lock
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;

    // Pin carries the block's drive once enabled, else the strap resistor
    assign strap_in = strap_oe_n ? strap_level : strap_out;

    // Lock comes late on purpose, so blocking before lock is visible
    always @(posedge sys_clk)
    begin
        if (rst || !synth_run)
            cnt <= 0;
        else if (cnt < LOCK_DELAY)
            cnt <= cnt + 1;
    end
    assign pll_lock = (cnt == LOCK_DELAY);
endmodule

`default_nettype wire

// ---- verification/cop_clock_control_bench.sv ----
`include "cop_map.svh"
`default_nettype none

module cop_clock_control_bench;
    import cop_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ----
    // Signals
    // ----
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic power_good_n_powerdown = 1'b0;
    logic [5:0] pair_enable_n = 6'h3f;
    logic [1:0] spread_strap = 2'h0;
    logic xtal_level = 1'b0;
    logic strap_level = 1'b0;
    logic pll_lock, strap_in, strap_out, strap_oe_n, synth_run;
    logic [5:0] diff_true, diff_comp;
    logic [6:0] smbus_addr;
    cop_spread_e spread_sel;
    logic [31:0] seed = 32'h49;
    int miscompares = 0;
    int checks_done = 0;

    cop_clock_control u_dut (.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .power_good_n_powerdown(power_good_n_powerdown), .pair_enable_n(pair_enable_n),
        .spread_strap(spread_strap), .xtal_level(xtal_level), .pll_lock(pll_lock),
        .address_strap_in(strap_in), .address_strap_out(strap_out), .address_strap_oe_n(strap_oe_n),
        .diff_true(diff_true), .diff_comp(diff_comp), .smbus_addr(smbus_addr),
        .spread_sel(spread_sel), .synth_run(synth_run));

    cop_board_model u_board (.sys_clk(sys_clk), .rst(rst), .synth_run(synth_run), .strap_out(strap_out),
        .strap_oe_n(strap_oe_n), .strap_level(strap_level), .strap_in(strap_in), .pll_lock(pll_lock));

    // Clock and a crystal that flips every cycle
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        xtal_level <= ~xtal_level;

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [31:0] exp_spread(input logic [1:0] c);
        return (c == 2'h0) ? 32'(SPREAD_OFF) : (c == 2'h1) ? 32'(SPREAD_QUARTER) : 32'(SPREAD_HALF);
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Each bus task idles a cycle after its strobe so calls may follow directly
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
        @(posedge sys_clk);
    endtask

    // Four cycles: which pairs toggled, and how often the reference was high
    task automatic observe(output logic [5:0] act, output int ones);
        act = 6'h00;
        ones = 0;
        repeat (4)
        begin
            @(posedge sys_clk);
            #1;
            act = act | diff_true | diff_comp;
            ones += int'(strap_out === 1'b1);
        end
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        power_good_n_powerdown <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask

    // Hang guard at 5000 cycles, far beyond the expected run of about 360 cycles
    initial
    begin
        #(5000 * 50);
        miscompares++;
        give_verdict();
    end

    // ----
    // Tests
    // ----
    initial
    begin
        logic [31:0] rd;
        logic [5:0] act, en, pins;
        int n, ones;
        for (int c = 0; c < 3; c++)
        begin
            do_reset();
            check("ref tristate", 32'h1, 32'(strap_oe_n));
            check("legs idle", 32'h0, 32'({diff_true, diff_comp}));
            if (c == 0)
            begin
                bus_read(`COP_OFS_PAIR_EN, rd);
                check("pair enable reset", 32'h3f, rd);
                bus_read(`COP_OFS_CFG3, rd);
                check("cfg3 reset", 32'h5f, rd);
                bus_write(8'h10, 32'hffffffff);
                bus_read(8'h10, rd);
                check("unmapped read", 32'h0, rd);
            end
            spread_strap <= 2'(c);
            strap_level <= c[0];
            @(posedge sys_clk);
            power_good_n_powerdown <= 1'b1;
            repeat (2) @(posedge sys_clk);
            #1;
            check("bus address", 32'(c[0] ? 7'h6a : 7'h68), 32'(smbus_addr));
            check("spread", exp_spread(2'(c)), 32'(spread_sel));
            check("ref driven", 32'h0, 32'(strap_oe_n));
            check("synth on", 32'h1, 32'(synth_run));
            strap_level <= ~c[0];
            spread_strap <= 2'(2 - c);
            repeat (3) @(posedge sys_clk);
            #1;
            check("address held", 32'(c[0] ? 7'h6a : 7'h68), 32'(smbus_addr));
            check("spread held", exp_spread(2'(c)), 32'(spread_sel));
            check("ref copy", {31'h0, ~xtal_level}, 32'(strap_out));
            $display("strap case %0d done", c);
        end
        // Pins enabled so that only the missing lock can keep the pairs quiet
        pair_enable_n <= 6'h00;
        observe(act, ones);
        check("blocked before lock", 32'h0, 32'(act));
        repeat (24) @(posedge sys_clk);
        for (int i = 0; i < 12; i++)
        begin
            seed = xorshift(seed);
            en = (i == 0) ? 6'h3f : (i == 1) ? 6'h00 : seed[5:0];
            pins = (i < 2) ? 6'h00 : (i == 2) ? 6'h3f : seed[13:8];
            bus_write(`COP_OFS_PAIR_EN, {26'h0, en});
            pair_enable_n <= pins;
            repeat (8) @(posedge sys_clk);
            observe(act, ones);
            check("running pairs", 32'(en & ~pins), 32'(act));
            bus_read(`COP_OFS_STATUS, rd);
            check("status", {10'h0, en & ~pins, 1'b0, 7'h68, 4'h2, 4'h6}, rd);
        end
        $display("gating done");
        bus_write(`COP_OFS_PAIR_EN, 32'h3f);
        pair_enable_n <= 6'h3f;
        repeat (8) @(posedge sys_clk);
        pair_enable_n[0] <= 1'b0;
        n = 0;
        while (n < 10 && !(diff_true[0] | diff_comp[0]))
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("start latency", 32'h1, 32'(n >= 2 && n <= 6));
        pair_enable_n[0] <= 1'b1;
        n = 0;
        for (int k = 1; k <= 10; k++)
        begin
            @(posedge sys_clk);
            #1;
            if (diff_true[0] | diff_comp[0])
                n = k;
        end
        check("stop latency", 32'h1, 32'(n <= 6));
        $display("latency done");
        pair_enable_n <= 6'h00;
        repeat (8) @(posedge sys_clk);
        power_good_n_powerdown <= 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk);
        #1;
        check("legs off at once", 32'h0, 32'({diff_true, diff_comp}));
        observe(act, ones);
        check("pd legs", 32'h0, 32'(act));
        check("pd ref low", 32'h0, 32'(ones));
        check("pd ref driven", 32'h0, 32'(strap_oe_n));
        bus_read(`COP_OFS_STATUS, rd);
        check("pd state", 32'h3, 32'(rd[1:0]));
        check("pd synth off", 32'h0, 32'(synth_run));
        power_good_n_powerdown <= 1'b1;
        repeat (30) @(posedge sys_clk);
        observe(act, ones);
        check("wake pairs", 32'h3f, 32'(act));
        check("wake ref", 32'h2, 32'(ones));
        check("address kept", 32'h68, 32'(smbus_addr));
        bus_write(`COP_OFS_CFG3, 32'h7f);
        bus_read(`COP_OFS_CFG3, rd);
        check("cfg3 write", 32'h7f, rd);
        power_good_n_powerdown <= 1'b0;
        repeat (2) @(posedge sys_clk);
        observe(act, ones);
        check("wol legs", 32'h0, 32'(act));
        check("wol ref", 32'h2, 32'(ones));
        $display("power down done");
        give_verdict();
    end
endmodule

`default_nettype wire
